/* File: rtl/msx_pkg.sv */
package msx_pkg;

	// Instruction word width handed to the decoder
	localparam int INSTR_W = 16;

	// Thumb-style encodings of the miscellaneous group
	localparam logic [7:0] BREAKPOINT_INSTR_OP = 8'h_BE;     // Top byte of breakpoint
	localparam logic [10:0] CPS_OP = 11'h_5B3;   // Top bits of state change
	localparam logic [7:0] MOVR_OP = 8'h_46;     // Top byte of register move
	localparam logic [7:0] HINT_OP = 8'h_BF;     // Top byte of hint group
	localparam logic [11:0] BAR_OP = 12'h_F3B;   // First half of barriers
	localparam logic [7:0] SVC_OP = 8'h_DF;      // Top byte of supervisor call
	localparam logic [15:0] SG_OP = 16'h_E97F;   // Secure gateway first half
	localparam logic [11:0] TT_OP = 12'h_E84;    // Test-target first half
	localparam logic [10:0] SPR_OP = 11'h_79C;   // Special-register moves

	// Field positions
	localparam int CPS_DIS_BIT = 4;   // 1 = disable form (sets masks)
	localparam int CPS_I_BIT = 1;     // Interrupt mask selector
	localparam int CPS_F_BIT = 0;     // Fault mask selector
	localparam int BAR_KIND_LSB = 4;  // Barrier kind in second half
	localparam int BAR_OPT_LSB = 0;   // Barrier option in second half

	// Barrier option and kinds
	localparam logic [3:0] OPT_FULL_SYSTEM = 4'h_F;
	localparam logic [3:0] KIND_DSB = 4'h_4;
	localparam logic [3:0] KIND_DMB = 4'h_5;
	localparam logic [3:0] KIND_ISB = 4'h_6;

	// Hint codes in bits 7:4 of the hint group
	localparam logic [3:0] HINT_NOP = 4'h_0;
	localparam logic [3:0] HINT_YIELD = 4'h_1;
	localparam logic [3:0] HINT_WFE = 4'h_2;
	localparam logic [3:0] HINT_WFI = 4'h_3;
	localparam logic [3:0] HINT_SEV = 4'h_4;

	// Reset values
	localparam logic MASK_RESET = 1'b0;
	localparam logic [7:0] IMM_RESET = 8'h_00;

	// Decoded operation classes
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_BREAKPOINT_INSTR = 4'b0001,
		OP_CPS = 4'b0010,
		OP_DMB = 4'b0011,
		OP_DSB = 4'b0100,
		OP_ISB = 4'b0101,
		OP_MOV = 4'b0110,
		OP_SPR = 4'b0111,
		OP_NOP = 4'b1000,
		OP_SEV = 4'b1001,
		OP_SG = 4'b1010,
		OP_SVC = 4'b1011,
		OP_TT = 4'b1100,
		OP_WFE = 4'b1101,
		OP_WFI = 4'b1110,
		OP_YIELD = 4'b1111
	} msx_op_t;

	// Decoder result
	typedef struct packed {
		msx_op_t op;
		logic [7:0] imm;
		logic cps_disable;
		logic cps_i;
		logic cps_f;
		logic [3:0] bar_opt;
		logic [3:0] rd;
		logic [3:0] rm;
		logic [1:0] tt_variant;
	} msx_dec_t;

	// Condition flags
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} msx_flags_t;

	// Barrier state machine
	typedef enum logic [1:0] {
		BAR_IDLE = 2'b00,
		BAR_DRAIN = 2'b01,
		BAR_DONE = 2'b10
	} msx_bar_state_t;

	// Whole state of the executer
	typedef struct packed {
		logic interrupt_mask_bit;
		logic fault_mask_bit;
		msx_flags_t flags;
		logic debug_halt;
		logic [7:0] breakpoint_instr_imm;
		logic reg_we;
		logic [3:0] reg_wa;
		logic [31:0] reg_wd;
		msx_bar_state_t bar_state;
		logic hold_mem;
		logic stall;
		logic flush;
		msx_op_t last_op;
		logic done;
	} msx_state_t;

endpackage : msx_pkg

/* File: rtl/msx_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module msx_decode
	import msx_pkg::*;
(
	// Instruction halves
	input wire logic [INSTR_W-1:0] hw0,
	input wire logic [INSTR_W-1:0] hw1,
	// Decoded result
	output msx_dec_t dec
);

	// Pure decode; field extraction never alters execution
	always_comb
	begin
		dec = '0;
		dec.op = OP_NONE;
		dec.imm = hw0[7:0];
		dec.cps_disable = hw0[CPS_DIS_BIT];
		dec.cps_i = hw0[CPS_I_BIT];
		dec.cps_f = hw0[CPS_F_BIT];
		dec.bar_opt = hw1[BAR_OPT_LSB +: 4];
		dec.rd = {hw0[7], hw0[2:0]};
		dec.rm = hw0[6:3];
		dec.tt_variant = hw1[7:6];
		// Breakpoint: immediate kept only as a field
		if (hw0[15:8] == BREAKPOINT_INSTR_OP)
		begin
			dec.op = OP_BREAKPOINT_INSTR;
		end
		else if (hw0[15:5] == CPS_OP)
		begin
			dec.op = OP_CPS;
		end
		// Legacy copy alias shares the register move encoding
		else if (hw0[15:8] == MOVR_OP)
		begin
			dec.op = OP_MOV;
		end
		else if (hw0[15:8] == SVC_OP)
		begin
			dec.op = OP_SVC;
		end
		// Hints only when the low nibble is zero; else it is the if-then
		else if (hw0[15:8] == HINT_OP && hw0[3:0] == 4'h_0)
		begin
			unique case (hw0[7:4])
				HINT_NOP: dec.op = OP_NOP;
				HINT_YIELD: dec.op = OP_YIELD;
				HINT_WFE: dec.op = OP_WFE;
				HINT_WFI: dec.op = OP_WFI;
				HINT_SEV: dec.op = OP_SEV;
				default: dec.op = OP_NONE;
			endcase
		end
		else if (hw0 == SG_OP && hw1 == SG_OP)
		begin
			dec.op = OP_SG;
		end
		else if (hw0[15:4] == TT_OP)
		begin
			dec.op = OP_TT;
		end
		else if (hw0[15:5] == SPR_OP)
		begin
			dec.op = OP_SPR;
		end
		else if (hw0[15:4] == BAR_OP)
		begin
			unique case (hw1[BAR_KIND_LSB +: 4])
				KIND_DSB: dec.op = OP_DSB;
				KIND_DMB: dec.op = OP_DMB;
				KIND_ISB: dec.op = OP_ISB;
				default: dec.op = OP_NONE;
			endcase
		end
	end

endmodule : msx_decode
`default_nettype wire

/* File: rtl/msx_exec.sv */
`timescale 1ns/100ps
`default_nettype none

module msx_exec
	import msx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction issue
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr_hw0,
	input wire logic [INSTR_W-1:0] instr_hw1,
	input wire logic cond_pass,
	input wire logic in_if_then_block,
	input wire logic privileged,
	input wire logic debug_enable,
	input wire logic debug_resume,
	// Source operand for register moves
	input wire logic [31:0] src_value,
	// Memory system status
	input wire logic mem_outstanding,
	// Flags written by other instructions
	input wire logic flags_we,
	input wire msx_flags_t flags_in,
	// Architectural outputs
	output logic interrupt_mask_bit,
	output logic fault_mask_bit,
	output msx_flags_t flags,
	output logic debug_halt,
	output logic [7:0] breakpoint_instr_imm,
	// Register write port
	output logic reg_we,
	output logic [3:0] reg_wa,
	output logic [31:0] reg_wd,
	// Pipeline control
	output logic hold_mem,
	output logic stall,
	output logic flush,
	output msx_op_t last_op,
	output logic done
);

	msx_state_t q; // Registered state
	msx_state_t next_q; // Next state
	msx_dec_t dec; // Current decode
	logic accept; // Instruction issued this cycle
	logic exec_ok; // Issued and its condition holds

	// Instruction decoder
	msx_decode u_dec (
		.hw0(instr_hw0),
		.hw1(instr_hw1),
		.dec(dec)
	);

	// Debug halt blocks new issue; a DSB or ISB in progress does too
	assign accept = instr_valid && !q.debug_halt && !q.stall;
	// Breakpoint ignores the if-then condition
	assign exec_ok = accept && (cond_pass || !in_if_then_block ||
		dec.op == OP_BREAKPOINT_INSTR);

	// Next-state logic
	always_comb
	begin
		next_q = q;
		next_q.reg_we = 1'b0;
		next_q.flush = 1'b0;
		next_q.done = 1'b0;
		// Flags from other units; none of ours ever write them
		if (flags_we)
		begin
			next_q.flags = flags_in;
		end
		// Leave debug when the debugger resumes
		if (q.debug_halt && debug_resume)
		begin
			next_q.debug_halt = 1'b0;
		end
		// Barrier drain: hold later memory accesses until quiet
		unique case (q.bar_state)
			BAR_IDLE:
			begin
				next_q.hold_mem = 1'b0;
			end
			BAR_DRAIN:
			begin
				// DMB holds only memory traffic; DSB and ISB also stall issue
				if (!mem_outstanding)
				begin
					next_q.bar_state = BAR_DONE;
				end
			end
			BAR_DONE:
			begin
				next_q.bar_state = BAR_IDLE;
				next_q.hold_mem = 1'b0;
				next_q.stall = 1'b0;
				next_q.flush = (q.last_op == OP_ISB);
				next_q.done = 1'b1;
			end
			default:
			begin
				next_q.bar_state = BAR_IDLE;
			end
		endcase
		if (exec_ok)
		begin
			next_q.last_op = dec.op;
			next_q.done = 1'b1;
			unique case (dec.op)
				OP_BREAKPOINT_INSTR:
				begin
					// Immediate only mirrored for a debugger
					next_q.breakpoint_instr_imm = dec.imm;
					if (debug_enable)
					begin
						next_q.debug_halt = 1'b1;
					end
				end
				OP_CPS:
				begin
					// No privilege, no change to either mask
					if (privileged)
					begin
						if (dec.cps_i)
						begin
							next_q.interrupt_mask_bit = dec.cps_disable;
						end
						if (dec.cps_f)
						begin
							next_q.fault_mask_bit = dec.cps_disable;
						end
					end
				end
				OP_DMB, OP_DSB, OP_ISB:
				begin
					// Every option, reserved or not, runs full-system
					next_q.bar_state = BAR_DRAIN;
					next_q.hold_mem = 1'b1;
					// Only the sync barriers stall later instructions
					next_q.stall = (dec.op != OP_DMB);
					next_q.done = 1'b0;
				end
				OP_MOV:
				begin
					// Copy alias and move produce the same write
					next_q.reg_we = 1'b1;
					next_q.reg_wa = dec.rd;
					next_q.reg_wd = src_value;
				end
				default:
				begin
					// Other group members are reported through last_op
					next_q.done = 1'b1;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			q <= '0;
			q.interrupt_mask_bit <= MASK_RESET;
			q.fault_mask_bit <= MASK_RESET;
			q.breakpoint_instr_imm <= IMM_RESET;
			q.bar_state <= BAR_IDLE;
			q.last_op <= OP_NONE;
		end
		else
		begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register
	assign interrupt_mask_bit = q.interrupt_mask_bit;
	assign fault_mask_bit = q.fault_mask_bit;
	assign flags = q.flags;
	assign debug_halt = q.debug_halt;
	assign breakpoint_instr_imm = q.breakpoint_instr_imm;
	assign reg_we = q.reg_we;
	assign reg_wa = q.reg_wa;
	assign reg_wd = q.reg_wd;
	assign hold_mem = q.hold_mem;
	assign stall = q.stall;
	assign flush = q.flush;
	assign last_op = q.last_op;
	assign done = q.done;

endmodule : msx_exec
`default_nettype wire

/* File: tb/msx_exec_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module msx_exec_chk
	import msx_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Issue side
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr_hw0,
	input wire logic [INSTR_W-1:0] instr_hw1,
	input wire logic privileged,
	input wire logic debug_enable,
	input wire logic in_if_then_block,
	input wire logic [31:0] src_value,
	input wire logic mem_outstanding,
	input wire logic flags_we,
	// Design outputs
	input wire logic interrupt_mask_bit,
	input wire logic fault_mask_bit,
	input wire msx_flags_t flags,
	input wire logic debug_halt,
	input wire logic [7:0] breakpoint_instr_imm,
	input wire logic reg_we,
	input wire logic [3:0] reg_wa,
	input wire logic [31:0] reg_wd,
	input wire logic hold_mem,
	input wire logic stall,
	input wire msx_op_t last_op,
	input wire logic done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Issue that the core accepts; halt and stall drop it silently
	wire logic go = instr_valid && !debug_halt && !stall;
	wire logic top = !in_if_then_block;
	wire logic processor_state_change = go && top && instr_hw0[15:5] == CPS_OP;
	wire logic register_move = go && top && instr_hw0[15:8] == MOVR_OP;
	wire logic bkp = go && instr_hw0[15:8] == BREAKPOINT_INSTR_OP;
	wire logic data_memory_barrier = go && top && instr_hw0[15:4] == BAR_OP
		&& instr_hw1[7:4] == KIND_DMB;
	// Fields captured for comparison one cycle later
	wire logic [7:0] imm = instr_hw0[7:0];
	wire logic dis = instr_hw0[CPS_DIS_BIT];
	wire logic [3:0] rd = {instr_hw0[7], instr_hw0[2:0]};

	a_breakpoint_instr_halt: assert property (bkp && debug_enable |=> debug_halt)
		else $error("breakpoint did not halt");
	a_breakpoint_instr_uncond: assert property (bkp |=> last_op == OP_BREAKPOINT_INSTR)
		else $error("breakpoint skipped");
	a_breakpoint_instr_field: assert property (bkp |=> breakpoint_instr_imm == $past(imm))
		else $error("breakpoint field wrong");
	a_flags_kept: assert property (!flags_we |=> $stable(flags))
		else $error("flags changed");
	a_irq_sel: assert property (processor_state_change && privileged && instr_hw0[CPS_I_BIT]
		|=> interrupt_mask_bit == $past(dis))
		else $error("interrupt mask wrong");
	a_fault_sel: assert property (processor_state_change && privileged && instr_hw0[CPS_F_BIT]
		|=> fault_mask_bit == $past(dis))
		else $error("fault mask wrong");
	a_unpriv_noop: assert property (processor_state_change && !privileged
		|=> $stable({interrupt_mask_bit, fault_mask_bit}))
		else $error("unprivileged change took effect");
	a_copy_move: assert property (register_move |=> reg_we && reg_wa == $past(rd)
		&& reg_wd == $past(src_value))
		else $error("register move wrong");
	a_barrier_hold: assert property (data_memory_barrier |=> hold_mem)
		else $error("barrier did not hold");
	a_drain_wait: assert property (hold_mem && mem_outstanding |=> hold_mem)
		else $error("hold dropped early");
	a_drain_end: assert property (hold_mem && !mem_outstanding
		|-> ##[1:3] done)
		else $error("barrier never completed");

	c_halt: cover property (bkp ##1 debug_halt);
	c_unpriv: cover property (processor_state_change && !privileged);
	c_barrier: cover property (data_memory_barrier ##[1:20] done);
endmodule : msx_exec_chk
bind msx_exec msx_exec_chk u_chk (.*);
`default_nettype wire

/* File: tb/msx_exec_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: %h expected %h", $time, a, b); end end
module msx_exec_bench
	import msx_pkg::*;
;
	// Stimulus, all driven from time zero
	logic clk = 0, rst = 1, instr_valid = 0, cond_pass = 1;
	logic in_if_then_block = 0, privileged = 1, debug_enable = 1;
	logic debug_resume = 0, mem_outstanding = 0, flags_we = 0;
	logic [15:0] instr_hw0 = '0, instr_hw1 = '0;
	logic [31:0] src_value = '0;
	msx_flags_t flags_in = '0;
	// Observed outputs
	logic interrupt_mask_bit, fault_mask_bit, debug_halt, reg_we;
	logic hold_mem, stall, flush, done;
	msx_flags_t flags;
	logic [7:0] breakpoint_instr_imm;
	logic [3:0] reg_wa;
	logic [31:0] reg_wd;
	msx_op_t last_op;
	int mismatches = 0, num_checks = 0, k;
	// State change table: code, privilege bit, expected {i, f}
	logic [15:0] cps_code [4] = '{16'h_B673, 16'h_B662, 16'h_B661, 16'h_B661};
	logic [3:0] cps_priv = 4'h_B;
	logic [1:0] cps_exp [4] = '{2'h_3, 2'h_1, 2'h_1, 2'h_0};
	// Hint group and supervisor call
	logic [15:0] op_code [6] = '{16'h_BF00, 16'h_BF10, 16'h_BF20,
		16'h_BF30, 16'h_BF40, 16'h_DF07};
	msx_op_t op_exp [6] = '{OP_NOP, OP_YIELD, OP_WFE, OP_WFI, OP_SEV, OP_SVC};
	// Full-system option first, then reserved ones
	logic [3:0] bar_opt [3] = '{4'h_F, 4'h_3, 4'h_0};

	msx_exec DUT (.*);

	always #50 clk = ~clk;

	task automatic wrap_up;
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// One-cycle issue; results settle at the following edge
	task automatic issue(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_hw0 <= a;
		instr_hw1 <= b;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
	endtask : issue

	// Bounded wait, since a lost completion would hang the run
	task automatic wait_done;
		// Step off the launching edge so an old done pulse is not seen
		@(posedge clk) #1;
		for (k = 0; k < 8 && done !== 1'b1; k++)
			@(posedge clk) #1;
		`CHK(done, 1'b1)
	endtask : wait_done

	// Watchdog at 1000 cycles, far beyond the roughly 80 cycles needed
	initial
	begin
		#100_000;
		mismatches++;
		wrap_up();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		flags_we <= 1'b1;
		flags_in <= 4'h_A;
		@(posedge clk);
		flags_we <= 1'b0;
		`CHK({interrupt_mask_bit, fault_mask_bit, debug_halt}, 3'h_0)
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			privileged <= cps_priv[i];
			issue(cps_code[i], 16'h_0000);
			`CHK({interrupt_mask_bit, fault_mask_bit}, cps_exp[i])
			`CHK(done, 1'b1)
		end
		`CHK(flags, 4'h_A)
		for (int i = 0; i < 6; i++)
		begin
			issue(op_code[i], 16'h_0000);
			`CHK(last_op, op_exp[i])
		end
		// Two-halfword members of the group
		issue(16'h_E97F, 16'h_E97F);
		`CHK(last_op, OP_SG)
		issue(16'h_E840, 16'h_F000);
		`CHK(last_op, OP_TT)
		issue(16'h_F380, 16'h_8800);
		`CHK(last_op, OP_SPR)
		@(posedge clk);
		src_value <= 32'h_1234_5678;
		issue(16'h_4681, 16'h_0000);
		`CHK({reg_we, reg_wa, reg_wd}, {1'b1, 4'h_9, 32'h_1234_5678})
		// Breakpoint under a failing if-then condition
		@(posedge clk);
		in_if_then_block <= 1'b1;
		cond_pass <= 1'b0;
		issue(16'h_BE5A, 16'h_0000);
		`CHK({debug_halt, breakpoint_instr_imm, flags}, {1'b1, 8'h_5A, 4'h_A})
		@(posedge clk);
		in_if_then_block <= 1'b0;
		cond_pass <= 1'b1;
		issue(16'h_B673, 16'h_0000);
		`CHK(interrupt_mask_bit, 1'b0)
		@(posedge clk);
		debug_resume <= 1'b1;
		@(posedge clk);
		debug_resume <= 1'b0;
		@(posedge clk) #1;
		`CHK(debug_halt, 1'b0)
		// Barrier per option; a move still runs during the drain
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			mem_outstanding <= 1'b1;
			issue(16'h_F3BF, {8'h_8F, KIND_DMB, bar_opt[i]});
			`CHK({hold_mem, done}, 2'h_2)
			issue(16'h_4681, 16'h_0000);
			`CHK({reg_we, hold_mem}, 2'h_3)
			@(posedge clk);
			mem_outstanding <= 1'b0;
			wait_done();
			`CHK(hold_mem, 1'b0)
		end
		// Sync barriers stall issue; only the instruction one flushes
		issue(16'h_F3BF, {8'h_8F, KIND_DSB, 4'h_F});
		`CHK({stall, hold_mem, last_op}, {2'h_3, OP_DSB})
		wait_done();
		`CHK({flush, stall}, 2'h_0)
		issue(16'h_F3BF, {8'h_8F, KIND_ISB, 4'h_F});
		`CHK({stall, hold_mem, last_op}, {2'h_3, OP_ISB})
		wait_done();
		`CHK({flush, stall}, 2'h_2)
		wrap_up();
	end
endmodule : msx_exec_bench
`default_nettype wire
